//--- rffcs_cal_model.sv
`timescale 1ns/1ps
`default_nettype none
module rffcs_cal_model
#(
  parameter logic [3:0] GEAR  = 4'h9,
  parameter logic [9:0] VALUE = 10'h155
)(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       cal_start,
  output var  logic       cal_done,
  output var  logic [3:0] cal_gear_result,
  output var  logic [9:0] cal_value
);
  logic [3:0] cnt;
  logic       slow;
  // answer each start not overtaken by another, fast then slow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 4'h0;
      slow <= 1'b0;
      cal_done <= 1'b0;
      cal_gear_result <= ~GEAR;
      cal_value <= ~VALUE;
    end else begin
      cal_done <= 1'b0;
      // results toggle outside done, never left looking valid
      cal_gear_result <= ~cal_gear_result;
      cal_value <= ~cal_value;
      if (cal_start) begin
        cnt <= slow ? 4'h6 : 4'h2;
        slow <= ~slow;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          cal_done <= 1'b1;
          cal_gear_result <= GEAR;
          cal_value <= VALUE;
        end
      end
    end
  end
endmodule : rffcs_cal_model
`default_nettype wire

//--- rffcs_pkg.sv
`default_nettype none
package rffcs_pkg;

  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned WORD_BYTES = 4;

  // register indices; byte address is index times word size
  localparam logic [ADDR_W-1:0] IDX_TX_CLK  = 8'h21;
  localparam logic [ADDR_W-1:0] IDX_RX      = 8'h22;
  localparam logic [ADDR_W-1:0] IDX_LD      = 8'h23;
  localparam logic [ADDR_W-1:0] IDX_STATUS  = 8'h24;
  localparam logic [ADDR_W-1:0] IDX_TEMP    = 8'h25;
  localparam logic [ADDR_W-1:0] IDX_GAIN    = 8'h26;
  localparam logic [ADDR_W-1:0] IDX_IRQ_ST  = 8'h2A;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MSK = 8'h2B;

  // writable bits of the configuration and gain words; their other bits read zero except the gain value in bits 9:0
  localparam logic [31:0] MASK_TX_CLK = 32'h0004_3FFF;
  localparam logic [31:0] MASK_RX     = 32'h0000_00FF;
  localparam logic [31:0] MASK_LD     = 32'h0000_7FFF;
  localparam logic [31:0] MASK_TEMP   = 32'h0000_000F;
  localparam logic [31:0] MASK_GEAR   = 32'h0000_3C00;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;

  // field positions
  localparam int unsigned TX_ALM      = 18;
  localparam int unsigned TX_PHASE_LO = 11;
  localparam int unsigned TX_PREV_LO  = 8;
  localparam int unsigned TX_INV2_RM  = 7;
  localparam int unsigned TX_INV2_CM  = 6;
  localparam int unsigned TX_INV1_RM  = 5;
  localparam int unsigned TX_INV1_CM  = 4;
  localparam int unsigned TX_MODE_LO  = 1;
  localparam int unsigned TX_DPLL     = 0;
  localparam int unsigned RX_SENS_LO  = 6;
  localparam int unsigned RX_MIX_LO   = 4;
  localparam int unsigned RECEIVE_HIGHPASS_CORNER_LO  = 2;
  localparam int unsigned RX_GAIN_LO  = 0;
  localparam int unsigned LD_PD       = 14;
  localparam int unsigned LD_SRC_LO   = 12;
  localparam int unsigned LD_LVL_LO   = 8;
  localparam int unsigned LD_REFA_LO  = 4;
  localparam int unsigned LD_REFB_LO  = 0;
  localparam int unsigned TP_HYST     = 3;
  localparam int unsigned TP_EN       = 2;
  localparam int unsigned TP_DELTA_LO = 0;
  localparam int unsigned GR_GEAR_LO  = 10;
  localparam int unsigned GR_VAL_LO   = 0;

  // codes
  localparam logic [1:0] MIX_READER = 2'h1;
  localparam logic [1:0] MIX_CARD   = 2'h2;
  localparam logic [1:0] SRC_NFC    = 2'h0;
  localparam logic [1:0] SRC_RF     = 2'h1;
  localparam logic [1:0] SRC_BOTH   = 2'h2;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  // interrupt status bits
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned IRQ_CMD_ERR = 0;
  localparam int unsigned IRQ_STBY    = 1;
  localparam int unsigned IRQ_CAL     = 2;
  localparam int unsigned IRQ_REG_OK  = 3;
  localparam int unsigned SYNC_W      = 12;

  typedef enum logic [3:0] {
    SEL_TX_CLK  = 4'h0,
    SEL_RX      = 4'h1,
    SEL_LD      = 4'h2,
    SEL_STATUS  = 4'h3,
    SEL_TEMP    = 4'h4,
    SEL_GAIN    = 4'h5,
    SEL_IRQ_ST  = 4'h6,
    SEL_IRQ_MSK = 4'h7,
    SEL_NONE    = 4'hF
  } rffcs_sel_t;

  // order matches the status word, bit 9 down to bit 0
  typedef struct packed {
    logic regulator_output_ready;
    logic parameter_error;
    logic syntax_error;
    logic semantic_error;
    logic standby_blocked_by_field;
    logic boot_cause_temp;
    logic boot_cause_soft_reset;
    logic boot_cause_wake_counter;
    logic boot_cause_field_detect;
    logic boot_cause_power_on;
  } rffcs_status_t;

  typedef struct packed {
    logic       active_load_mod_enable;
    logic [2:0] recovered_clock_phase_step;
    logic [2:0] driver_clock_mode;
    logic       driver_one_invert;
    logic       driver_two_invert;
    logic       digital_pll_enable;
    logic       reader_mixer_enable;
    logic       card_mixer_enable;
    logic [1:0] receive_highpass_corner;
    logic [1:0] baseband_gain;
    logic [1:0] miller_sens;
    logic       field_level_detector_powerdown;
    logic       field_detected;
    logic [3:0] detect_level;
    logic [3:0] level_ref_a;
    logic [3:0] level_ref_b;
    logic       temp_sensor_enable;
    logic       thermal_hysteresis_enable;
    logic [1:0] temp_threshold;
  } rffcs_cfg_t;

endpackage : rffcs_pkg
`default_nettype wire

//--- rffcs_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rffcs_regs
  import rffcs_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  output var  logic [1:0]          s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  output var  logic [DATA_W-1:0]   s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire rffcs_status_t       status_pins,
  input  wire logic                nfc_level_pin,
  input  wire logic                rf_level_pin,
  input  wire logic                card_mode,
  input  wire logic                prevention_active,
  input  wire logic                cal_done,
  input  wire logic [3:0]          cal_gear_result,
  input  wire logic [9:0]          cal_value,
  output var  rffcs_cfg_t          cfg,
  output var  logic                cal_start,
  output var  logic                cal_use_dpc_gear,
  output var  logic [3:0]          calibration_gear,
  output var  logic                irq
);

  //////////////////////////////////////////////////////////////////////////
  // word index only; low address bits ignored, no sub-word decode
  function automatic rffcs_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] idx;
    idx = ADDR_W'(a / WORD_BYTES);
    case (idx)
      IDX_TX_CLK:  decode = SEL_TX_CLK;
      IDX_RX:      decode = SEL_RX;
      IDX_LD:      decode = SEL_LD;
      IDX_STATUS:  decode = SEL_STATUS;
      IDX_TEMP:    decode = SEL_TEMP;
      IDX_GAIN:    decode = SEL_GAIN;
      IDX_IRQ_ST:  decode = SEL_IRQ_ST;
      IDX_IRQ_MSK: decode = SEL_IRQ_MSK;
      default:     decode = SEL_NONE;
    endcase
  endfunction : decode

  // byte lanes and writable mask; reserved bits never take a one
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~(lanes & mask)) | (data & lanes & mask);
  endfunction : merge

  //////////////////////////////////////////////////////////////////////////
  // three-stage synchroniser, change taken once stages two and three agree
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] pin_flt;
  logic [SYNC_W-1:0] agree;

  // a pin caught mid-change keeps its last agreed level
  assign agree = sync2 ~^ sync3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1   <= '0;
      sync2   <= '0;
      sync3   <= '0;
      pin_flt <= '0;
    end else begin
      sync1   <= {nfc_level_pin, rf_level_pin, status_pins};
      sync2   <= sync1;
      sync3   <= sync2;
      pin_flt <= (pin_flt & ~agree) | (sync2 & agree);
    end
  end

  rffcs_status_t st;
  logic          nfc_ind;
  logic          rf_ind;
  assign st      = rffcs_status_t'(pin_flt[$bits(rffcs_status_t)-1:0]);
  assign rf_ind  = pin_flt[$bits(rffcs_status_t)];
  assign nfc_ind = pin_flt[SYNC_W-1];

  //////////////////////////////////////////////////////////////////////////
  // bus handshakes
  rffcs_sel_t        wsel;
  rffcs_sel_t        rsel;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  logic              rd_fire;

  // both halves parked until the response, so either may come first
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wsel    = decode(aw_addr);
  assign rsel    = decode(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == SEL_NONE) ? RESP_SLV : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration words
  logic [31:0] tx_clk_reg;
  logic [31:0] rx_reg;
  logic [31:0] ld_reg;
  logic [31:0] temp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_clk_reg <= RESET_WORD;
      rx_reg     <= RESET_WORD;
      ld_reg     <= RESET_WORD;
      temp_reg   <= RESET_WORD;
    end else if (wr_fire) begin
      // masked write keeps reserved bits zero
      case (wsel)
        SEL_TX_CLK: tx_clk_reg <= merge(tx_clk_reg, w_data, w_strb,
                                        MASK_TX_CLK);
        SEL_RX:     rx_reg     <= merge(rx_reg, w_data, w_strb, MASK_RX);
        SEL_LD:     ld_reg     <= merge(ld_reg, w_data, w_strb, MASK_LD);
        SEL_TEMP:   temp_reg   <= merge(temp_reg, w_data, w_strb,
                                        MASK_TEMP);
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // gain reference and calibration
  logic [31:0] gear_word;
  logic [9:0]  gain_reference_value;
  logic        written_since_read;

  // gear lanes merged onto the old gear; value bits of a write dropped
  assign gear_word = merge({18'h0, calibration_gear, 10'h0}, w_data,
                           w_strb, MASK_GEAR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      calibration_gear     <= 4'h0;
      gain_reference_value <= 10'h000;
      written_since_read   <= 1'b0;
      cal_start            <= 1'b0;
      cal_use_dpc_gear     <= 1'b0;
    end else begin
      cal_start <= 1'b0;
      // a finish meeting a new start is dropped; the new cycle answers
      if (wr_fire && wsel == SEL_GAIN) begin
        // host sets gear; value bits ignored, cycle derives it
        calibration_gear   <= gear_word[GR_GEAR_LO +: 4];
        written_since_read <= 1'b1;
        cal_start          <= 1'b1;
        cal_use_dpc_gear   <= 1'b0;
      end else if (rd_fire && rsel == SEL_GAIN) begin
        written_since_read <= 1'b0;
        // plain read starts calibration from power-control gear
        if (!written_since_read) begin
          cal_start        <= 1'b1;
          cal_use_dpc_gear <= 1'b1;
        end
      end else if (cal_done) begin
        gain_reference_value <= cal_value;
        if (cal_use_dpc_gear) begin
          calibration_gear <= cal_gear_result;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt status, set beats write-one-to-clear
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;
  rffcs_status_t    st_prev;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] next_irq_mask;

  assign irq_event[IRQ_CMD_ERR] =
    (st.parameter_error & ~st_prev.parameter_error) |
    (st.syntax_error & ~st_prev.syntax_error) |
    (st.semantic_error & ~st_prev.semantic_error);
  assign irq_event[IRQ_STBY] =
    st.standby_blocked_by_field & ~st_prev.standby_blocked_by_field;
  assign irq_event[IRQ_CAL] = cal_done;
  assign irq_event[IRQ_REG_OK] =
    st.regulator_output_ready & ~st_prev.regulator_output_ready;
  assign irq_clear = (wr_fire && wsel == SEL_IRQ_ST && w_strb[0])
                     ? w_data[IRQ_W-1:0] : '0;
  assign next_irq_status = (irq_status & ~irq_clear) | irq_event;
  assign next_irq_mask   = (wr_fire && wsel == SEL_IRQ_MSK && w_strb[0])
                           ? w_data[IRQ_W-1:0] : irq_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq_mask   <= '0;
      st_prev    <= '0;
      irq        <= 1'b0;
    end else begin
      st_prev    <= st;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      // built from next values so the pin tracks the sticky bits
      irq        <= |(next_irq_status & next_irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read path
  logic [31:0] read_word;

  always_comb begin
    read_word = '0;
    case (rsel)
      SEL_TX_CLK:  read_word = tx_clk_reg;
      SEL_RX:      read_word = rx_reg;
      SEL_LD:      read_word = ld_reg;
      SEL_STATUS:  read_word = {22'h0, st};
      SEL_TEMP:    read_word = temp_reg;
      SEL_GAIN:    read_word = {18'h0, calibration_gear,
                                gain_reference_value};
      SEL_IRQ_ST:  read_word = {28'h0, irq_status};
      SEL_IRQ_MSK: read_word = {28'h0, irq_mask};
      default:     read_word = '0;
    endcase
  end

  // data captured at the take; a later write cannot tear a read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= read_word;
      s_axi_rresp   <= (rsel == SEL_NONE) ? RESP_SLV : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // decoded controls toward the analog front end
  logic [1:0] mix_code;
  logic       nfc_det;
  assign mix_code = rx_reg[RX_MIX_LO +: 2];
  assign nfc_det  = nfc_ind & ~ld_reg[LD_PD];

  // every control leaves on a flop, one cycle after its bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= '0;
    end else begin
      // active load modulation only in card mode
      cfg.active_load_mod_enable <= tx_clk_reg[TX_ALM] & card_mode;
      // phase step, 45 degrees per count
      cfg.recovered_clock_phase_step <= tx_clk_reg[TX_PHASE_LO +: 3];
      // prevention mode overrides the reader clock mode
      cfg.driver_clock_mode <= prevention_active
                               ? tx_clk_reg[TX_PREV_LO +: 3]
                               : tx_clk_reg[TX_MODE_LO +: 3];
      // inversion bit of the current mode only
      cfg.driver_one_invert <= card_mode ? tx_clk_reg[TX_INV1_CM]
                                         : tx_clk_reg[TX_INV1_RM];
      cfg.driver_two_invert <= card_mode ? tx_clk_reg[TX_INV2_CM]
                                         : tx_clk_reg[TX_INV2_RM];
      cfg.digital_pll_enable <= tx_clk_reg[TX_DPLL];
      // mixer selection, other codes power both down
      cfg.reader_mixer_enable <= (mix_code == MIX_READER);
      cfg.card_mixer_enable   <= (mix_code == MIX_CARD);
      // corner code passed to the filter
      cfg.receive_highpass_corner <= rx_reg[RECEIVE_HIGHPASS_CORNER_LO +: 2];
      // gain code passed to the amplifier
      cfg.baseband_gain <= rx_reg[RX_GAIN_LO +: 2];
      cfg.miller_sens   <= rx_reg[RX_SENS_LO +: 2];
      cfg.field_level_detector_powerdown <= ld_reg[LD_PD];
      case (ld_reg[LD_SRC_LO +: 2])
        SRC_NFC:  cfg.field_detected <= nfc_det;
        SRC_RF:   cfg.field_detected <= rf_ind;
        SRC_BOTH: cfg.field_detected <= nfc_det | rf_ind;
        default:  cfg.field_detected <= 1'b1;
      endcase
      cfg.detect_level <= ld_reg[LD_LVL_LO +: 4];
      cfg.level_ref_a  <= ld_reg[LD_REFA_LO +: 4];
      cfg.level_ref_b  <= ld_reg[LD_REFB_LO +: 4];
      cfg.temp_sensor_enable        <= temp_reg[TP_EN];
      cfg.thermal_hysteresis_enable <= temp_reg[TP_HYST];
      cfg.temp_threshold            <= temp_reg[TP_DELTA_LO +: 2];
    end
  end

endmodule : rffcs_regs
`default_nettype wire

//--- rffcs_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rffcs_regs_assertions
  import rffcs_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        card_mode,
  input wire logic        cal_done,
  input wire logic [3:0]  cal_gear_result,
  input wire rffcs_cfg_t  cfg,
  input wire logic        cal_start,
  input wire logic        cal_use_dpc_gear,
  input wire logic [3:0]  calibration_gear
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic gain_take_q;
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence dpc_done;
    cal_done && cal_use_dpc_gear && !cal_start;
  endsequence
  always_ff @(posedge aclk) begin
    gain_take_q <= aresetn && s_axi_arvalid && s_axi_arready
                   && s_axi_araddr / WORD_BYTES == IDX_GAIN;
  end
  ////////////////////////////////////////
  read_answer_a: assert property (
    rd_take |=> s_axi_rvalid) else $error("read not answered");
  reserved_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:19] == 13'h0000)
    else $error("reserved bits not zero");
  mixer_excl_a: assert property (
    !(cfg.reader_mixer_enable && cfg.card_mixer_enable))
    else $error("both mixers on");
  alm_reader_a: assert property (
    !card_mode [*2] |-> !cfg.active_load_mod_enable)
    else $error("load modulation outside card mode");
  cal_pulse_a: assert property (
    cal_start |=> !cal_start) else $error("start pulse too long");
  read_start_a: assert property (
    cal_start && cal_use_dpc_gear |-> gain_take_q)
    else $error("gear start without gain read");
  write_start_a: assert property (
    cal_start && !cal_use_dpc_gear |-> $rose(s_axi_bvalid))
    else $error("host gear start without write");
  gear_load_a: assert property (
    dpc_done |=> calibration_gear == $past(cal_gear_result))
    else $error("gear not loaded from cycle");
endmodule : rffcs_regs_assertions
bind rffcs_regs rffcs_regs_assertions CHK (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .card_mode(card_mode),
  .cal_done(cal_done), .cal_gear_result(cal_gear_result), .cfg(cfg),
  .cal_start(cal_start), .cal_use_dpc_gear(cal_use_dpc_gear),
  .calibration_gear(calibration_gear));
`default_nettype wire

//--- rffcs_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module rffcs_regs_test
  import rffcs_pkg::*;
;
  logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid, irq, rf_pin;
  logic          card_mode, prev, nfc_pin, cal_done, cal_start, use_dpc;
  logic [7:0]    awaddr, araddr;
  logic [31:0]   wdata, rdata, got;
  logic [1:0]    bresp, rresp, resp, c;
  logic [3:0]    cal_gear, gear;
  logic [9:0]    cal_value;
  rffcs_status_t pins;
  rffcs_cfg_t    cfg;
  int            n_mismatch = 0;
  int            checks = 0;
  logic [7:0]    adr [4] = '{8'h84, 8'h88, 8'h8C, 8'h94};
  logic [31:0]   msk [4] = '{MASK_TX_CLK, MASK_RX, MASK_LD, MASK_TEMP};

  rffcs_regs DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .status_pins(pins), .nfc_level_pin(nfc_pin), .rf_level_pin(rf_pin),
    .card_mode(card_mode), .prevention_active(prev),
    .cal_done(cal_done), .cal_gear_result(cal_gear),
    .cal_value(cal_value), .cfg(cfg), .cal_start(cal_start),
    .cal_use_dpc_gear(use_dpc), .calibration_gear(gear), .irq(irq));
  rffcs_cal_model CAL (
    .aclk(aclk), .aresetn(aresetn), .cal_start(cal_start),
    .cal_done(cal_done), .cal_gear_result(cal_gear),
    .cal_value(cal_value));
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic chk_resp(input string s, input logic [1:0] e);
    checks++;
    if (resp !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", s, e, resp);
    end
  endtask : chk_resp
  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask : settle
  // waits on the partner's finish; the watchdog bounds a hang
  task automatic wait_cal();
    while (cal_done !== 1'b1) @(posedge aclk);
    settle();
  endtask : wait_cal
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {card_mode, prev, nfc_pin, rf_pin} = 4'h2;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    pins = 10'h000;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(adr[i]);
      chk("reset", 32'h0, got);
      wr(adr[i], 32'hFFFF_FFFF);
      rd(adr[i]);
      chk("ones", msk[i], got);
    end
    settle();
    chk("temp en", 32'h1, cfg.temp_sensor_enable);
    chk("hyst", 32'h1, cfg.thermal_hysteresis_enable);
    chk("thresh", 32'h3, cfg.temp_threshold);
    chk("sens", 32'h3, cfg.miller_sens);
    chk("level", 32'hFFF,
        {cfg.detect_level, cfg.level_ref_a, cfg.level_ref_b});
    $display("test access done");
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(8'h84, {28'h0, 1'b0, c, 1'b0});
      wr(8'h88, {26'h0, c, c, ~c});
      wr(8'h8C, {18'h0, c, 12'h000});
      settle();
      chk("mode", c, cfg.driver_clock_mode);
      chk("rd mix", c == MIX_READER, cfg.reader_mixer_enable);
      chk("cd mix", c == MIX_CARD, cfg.card_mixer_enable);
      chk("corner", c, cfg.receive_highpass_corner);
      chk("gain", c ^ 2'h3, cfg.baseband_gain);
      chk("field", c != SRC_RF, cfg.field_detected);
    end
    wr(8'h8C, 32'h0000_4000);
    settle();
    chk("pd", 32'h1, cfg.field_level_detector_powerdown);
    chk("pd field", 32'h0, cfg.field_detected);
    rf_pin <= 1'b1;
    wr(8'h8C, 32'h0000_6000);
    settle();
    chk("both", 32'h1, cfg.field_detected);
    wr(8'h84, 32'h0004_2EA7);
    settle();
    chk("alm rd", 32'h0, cfg.active_load_mod_enable);
    chk("phase", 32'h5, cfg.recovered_clock_phase_step);
    chk("inv1 rd", 32'h1, cfg.driver_one_invert);
    chk("inv2 rd", 32'h1, cfg.driver_two_invert);
    chk("dpll", 32'h1, cfg.digital_pll_enable);
    @(posedge aclk);
    card_mode <= 1'b1;
    prev <= 1'b1;
    settle();
    chk("alm cd", 32'h1, cfg.active_load_mod_enable);
    chk("inv1 cd", 32'h0, cfg.driver_one_invert);
    chk("inv2 cd", 32'h0, cfg.driver_two_invert);
    chk("prev", 32'h6, cfg.driver_clock_mode);
    $display("test controls done");
    // second value flips every status bit
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      pins <= i ? 10'h2A5 : 10'h15A;
      repeat (8) @(posedge aclk);
      rd(8'h90);
      chk("status", i ? 32'h2A5 : 32'h15A, got);
    end
    wr(8'h90, 32'hFFFF_FFFF);
    chk_resp("st wr", RESP_OKAY);
    rd(8'h90);
    chk("st ro", 32'h2A5, got);
    rd(8'h00);
    chk_resp("bad rd", RESP_SLV);
    chk("bad data", 32'h0, got);
    wr(8'h00, 32'hFFFF_FFFF);
    chk_resp("bad wr", RESP_SLV);
    rd(8'hA8);
    chk("irq st", 32'hB, got);
    chk("irq off", 32'h0, irq);
    wr(8'hAC, 32'h4);
    wr(8'hA8, 32'hF);
    rd(8'hA8);
    chk("irq clr", 32'h0, got);
    $display("test status done");
    rd(8'h98);
    chk("gr0", 32'h0, got);
    chk("dpc", 32'h1, use_dpc);
    wait_cal();
    chk("irq on", 32'h1, irq);
    chk("gear", 32'h9, gear);
    wr(8'hA8, 32'h4);
    settle();
    chk("irq low", 32'h0, irq);
    rd(8'h98);
    chk("gr1", 32'h2555, got);
    wait_cal();
    wr(8'h98, 32'hFFFF_FFFF);
    chk("host", 32'h0, use_dpc);
    wait_cal();
    chk("gear w", 32'hF, gear);
    rd(8'h98);
    chk("gr2", 32'h3D55, got);
    chk("no cal", 32'h0, use_dpc);
    $display("test gain done");
    stop_test();
  end
endmodule : rffcs_regs_test
`default_nettype wire
